// [rtl/refcb_pkg.sv]
// Constants for the right-channel effects coefficient bank
package refcb_pkg;
    localparam int unsigned NUM_REGS = 10;
    localparam int unsigned NUM_COEFS = 5;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PAGE_W = 8;
    localparam int unsigned COEF_W = 16;
    localparam logic [PAGE_W-1:0] COEF_PAGE = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 7'h23;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 7'h2c;
    // Register offsets, upper byte first for each coefficient
    localparam logic [ADDR_W-1:0] RIGHT_FX_NUM4_HIGH = 7'h23;
    localparam logic [ADDR_W-1:0] RIGHT_FX_NUM4_LOW = 7'h24;
    localparam logic [ADDR_W-1:0] RIGHT_FX_NUM5_HIGH = 7'h25;
    localparam logic [ADDR_W-1:0] RIGHT_FX_NUM5_LOW = 7'h26;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN1_HIGH = 7'h27;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN1_LOW = 7'h28;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN2_HIGH = 7'h29;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN2_LOW = 7'h2a;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN4_HIGH = 7'h2b;
    localparam logic [ADDR_W-1:0] RIGHT_FX_DEN4_LOW = 7'h2c;
    // Reset values, indexed from ADDR_FIRST
    localparam logic [DATA_W-1:0] RESET_VAL [NUM_REGS] = '{
        8'h96, 8'h66,  // numerator_coef_4
        8'h67, 8'h5d,  // numerator_coef_5
        8'h7d, 8'h83,  // denominator_coef_1
        8'h84, 8'hee,  // denominator_coef_2
        8'h7d, 8'h83   // denominator_coef_4
    };
    // Coefficient slot numbers on the coef output
    localparam int unsigned SLOT_NUM4 = 0;
    localparam int unsigned SLOT_NUM5 = 1;
    localparam int unsigned SLOT_DEN1 = 2;
    localparam int unsigned SLOT_DEN2 = 3;
    localparam int unsigned SLOT_DEN4 = 4;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
endpackage : refcb_pkg

// [rtl/refcb_bank_if.sv]
// Write and readback path between decoder and byte storage
`timescale 1ns/1ps
interface refcb_bank_if #(
    parameter int unsigned N = refcb_pkg::NUM_REGS
);
    logic [N-1:0] wr_sel;
    logic [refcb_pkg::DATA_W-1:0] wdata;
    logic [refcb_pkg::DATA_W-1:0] bytes [N];

    modport ctrl (output wr_sel, output wdata, input bytes);
    modport store (input wr_sel, input wdata, output bytes);
endinterface : refcb_bank_if

// [rtl/refcb_byte_store.sv]
// Ten byte registers holding the coefficient halves
`timescale 1ns/1ps
module refcb_byte_store #(
    parameter int unsigned N = refcb_pkg::NUM_REGS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bank access
    refcb_bank_if.store bank
);
    logic [refcb_pkg::DATA_W-1:0] byte_q [N];
    logic [refcb_pkg::DATA_W-1:0] byte_d [N];

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_byte
            always_comb begin
                byte_d[i] = byte_q[i];
                if (bank.wr_sel[i]) begin
                    byte_d[i] = bank.wdata;  // see R07
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    byte_q[i] <= refcb_pkg::RESET_VAL[i];  // see R02 see R03 see R04 see R05 see R06
                end else begin
                    byte_q[i] <= byte_d[i];
                end
            end

            assign bank.bytes[i] = byte_q[i];
        end
    endgenerate
endmodule : refcb_byte_store

// [rtl/refcb_coef_bank.sv]
// Right-channel effects filter coefficient bank on the control port
`timescale 1ns/1ps
// Summary of operation
// R01: Each coefficient is a signed 16-bit value, upper byte bits 15:8, lower 7:0.
// R02: Numerator 4 resets to upper 0x96, lower 0x66.
// R03: Numerator 5 resets to upper 0x67, lower 0x5d.
// R04: Denominator 1 resets to upper 0x7d, lower 0x83.
// R05: Denominator 2 resets to upper 0x84, lower 0xee.
// R06: Denominator 4 resets to upper 0x7d, lower 0x83.
// R07: All ten bytes read and write fully; reads return last write or reset value.
// R08: Bank decodes only page 1, addresses 35 to 44, upper byte first; read valid still answers every read strobe, hit or miss.
module refcb_coef_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control port
    input wire logic [refcb_pkg::PAGE_W-1:0] page_sel,
    input wire logic [refcb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [refcb_pkg::DATA_W-1:0] reg_wdata,
    output logic [refcb_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_rd_hit,
    // Coefficients to the filter
    output logic signed [refcb_pkg::COEF_W-1:0] coef_num4,
    output logic signed [refcb_pkg::COEF_W-1:0] coef_num5,
    output logic signed [refcb_pkg::COEF_W-1:0] coef_den1,
    output logic signed [refcb_pkg::COEF_W-1:0] coef_den2,
    output logic signed [refcb_pkg::COEF_W-1:0] coef_den4
);
    localparam int unsigned N = refcb_pkg::NUM_REGS;
    localparam int unsigned IDX_W = $clog2(N);
    // Each coefficient takes two neighbouring byte slots in the store, upper byte first
    localparam int unsigned BYTES_PER_COEF = refcb_pkg::COEF_W / refcb_pkg::DATA_W;
    localparam int unsigned HIGH_SLOT = 0;
    localparam int unsigned LOW_SLOT = 1;
    // numerator_coef_4
    localparam logic [IDX_W-1:0] IDX_NUM4_HIGH = IDX_W'(refcb_pkg::SLOT_NUM4 * BYTES_PER_COEF + HIGH_SLOT);
    localparam logic [IDX_W-1:0] IDX_NUM4_LOW = IDX_W'(refcb_pkg::SLOT_NUM4 * BYTES_PER_COEF + LOW_SLOT);
    // numerator_coef_5
    localparam logic [IDX_W-1:0] IDX_NUM5_HIGH = IDX_W'(refcb_pkg::SLOT_NUM5 * BYTES_PER_COEF + HIGH_SLOT);
    localparam logic [IDX_W-1:0] IDX_NUM5_LOW = IDX_W'(refcb_pkg::SLOT_NUM5 * BYTES_PER_COEF + LOW_SLOT);
    // denominator_coef_1
    localparam logic [IDX_W-1:0] IDX_DEN1_HIGH = IDX_W'(refcb_pkg::SLOT_DEN1 * BYTES_PER_COEF + HIGH_SLOT);
    localparam logic [IDX_W-1:0] IDX_DEN1_LOW = IDX_W'(refcb_pkg::SLOT_DEN1 * BYTES_PER_COEF + LOW_SLOT);
    // denominator_coef_2
    localparam logic [IDX_W-1:0] IDX_DEN2_HIGH = IDX_W'(refcb_pkg::SLOT_DEN2 * BYTES_PER_COEF + HIGH_SLOT);
    localparam logic [IDX_W-1:0] IDX_DEN2_LOW = IDX_W'(refcb_pkg::SLOT_DEN2 * BYTES_PER_COEF + LOW_SLOT);
    // denominator_coef_4
    localparam logic [IDX_W-1:0] IDX_DEN4_HIGH = IDX_W'(refcb_pkg::SLOT_DEN4 * BYTES_PER_COEF + HIGH_SLOT);
    localparam logic [IDX_W-1:0] IDX_DEN4_LOW = IDX_W'(refcb_pkg::SLOT_DEN4 * BYTES_PER_COEF + LOW_SLOT);

    refcb_bank_if #(.N(N)) bank ();

    logic page_hit;
    logic window_hit;
    logic slot_hit;
    logic addr_hit;
    logic wr_accept;
    logic rd_accept;
    logic [IDX_W-1:0] idx;
    logic [refcb_pkg::DATA_W-1:0] rd_byte;
    logic [refcb_pkg::DATA_W-1:0] rdata_d;
    logic [refcb_pkg::DATA_W-1:0] rdata_q;
    logic rd_valid_d;
    logic rd_valid_q;
    logic rd_hit_d;
    logic rd_hit_q;
    logic signed [refcb_pkg::COEF_W-1:0] coef [refcb_pkg::NUM_COEFS];

    // Decode: other pages share these offsets, so the page must match too
    assign page_hit = (page_sel == refcb_pkg::COEF_PAGE);  // see R08
    assign window_hit = (reg_addr >= refcb_pkg::ADDR_FIRST) && (reg_addr <= refcb_pkg::ADDR_LAST);  // see R08

    // Offset to byte slot, written by register name so it reads like the register map
    always_comb begin
        slot_hit = 1'b1;
        idx = '0;
        case (reg_addr)
            // numerator_coef_4
            refcb_pkg::RIGHT_FX_NUM4_HIGH: begin
                idx = IDX_NUM4_HIGH;
            end
            refcb_pkg::RIGHT_FX_NUM4_LOW: begin
                idx = IDX_NUM4_LOW;
            end
            // numerator_coef_5
            refcb_pkg::RIGHT_FX_NUM5_HIGH: begin
                idx = IDX_NUM5_HIGH;
            end
            refcb_pkg::RIGHT_FX_NUM5_LOW: begin
                idx = IDX_NUM5_LOW;
            end
            // denominator_coef_1
            refcb_pkg::RIGHT_FX_DEN1_HIGH: begin
                idx = IDX_DEN1_HIGH;
            end
            refcb_pkg::RIGHT_FX_DEN1_LOW: begin
                idx = IDX_DEN1_LOW;
            end
            // denominator_coef_2
            refcb_pkg::RIGHT_FX_DEN2_HIGH: begin
                idx = IDX_DEN2_HIGH;
            end
            refcb_pkg::RIGHT_FX_DEN2_LOW: begin
                idx = IDX_DEN2_LOW;
            end
            // denominator_coef_4
            refcb_pkg::RIGHT_FX_DEN4_HIGH: begin
                idx = IDX_DEN4_HIGH;
            end
            refcb_pkg::RIGHT_FX_DEN4_LOW: begin
                idx = IDX_DEN4_LOW;
            end
            default: begin
                slot_hit = 1'b0;
                idx = '0;
            end
        endcase
    end

    // The window test guards the slot map against a mistyped offset
    assign addr_hit = page_hit && window_hit && slot_hit;  // see R08
    assign wr_accept = reg_wr_en && addr_hit;
    assign rd_accept = reg_rd_en && addr_hit;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_sel
            assign bank.wr_sel[i] = wr_accept && (idx == IDX_W'(i));  // see R08
        end
        for (i = 0; i < refcb_pkg::NUM_COEFS; i++) begin : g_coef
            // Bytes land one at a time, so between the two writes the filter sees a half-new value
            assign coef[i] = {
                bank.bytes[BYTES_PER_COEF * i + HIGH_SLOT],
                bank.bytes[BYTES_PER_COEF * i + LOW_SLOT]
            };  // see R01
        end
    endgenerate

    assign bank.wdata = reg_wdata;

    refcb_byte_store #(.N(N)) u_store (
        .clk(clk),
        .rst(rst),
        .bank(bank.store)
    );

    // Named legs keep the read mux to the ten real slots; any other index gives idle data
    always_comb begin
        rd_byte = refcb_pkg::RDATA_IDLE;
        case (idx)
            IDX_NUM4_HIGH: rd_byte = bank.bytes[IDX_NUM4_HIGH];
            IDX_NUM4_LOW: rd_byte = bank.bytes[IDX_NUM4_LOW];
            IDX_NUM5_HIGH: rd_byte = bank.bytes[IDX_NUM5_HIGH];
            IDX_NUM5_LOW: rd_byte = bank.bytes[IDX_NUM5_LOW];
            IDX_DEN1_HIGH: rd_byte = bank.bytes[IDX_DEN1_HIGH];
            IDX_DEN1_LOW: rd_byte = bank.bytes[IDX_DEN1_LOW];
            IDX_DEN2_HIGH: rd_byte = bank.bytes[IDX_DEN2_HIGH];
            IDX_DEN2_LOW: rd_byte = bank.bytes[IDX_DEN2_LOW];
            IDX_DEN4_HIGH: rd_byte = bank.bytes[IDX_DEN4_HIGH];
            IDX_DEN4_LOW: rd_byte = bank.bytes[IDX_DEN4_LOW];
            default: rd_byte = refcb_pkg::RDATA_IDLE;
        endcase
    end

    // Read data: a read in the same cycle as a write sees the old byte
    always_comb begin
        rdata_d = refcb_pkg::RDATA_IDLE;
        if (rd_accept) begin
            rdata_d = rd_byte;  // see R07
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= refcb_pkg::RDATA_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Read valid answers every read strobe, hit or miss
    always_comb begin
        rd_valid_d = reg_rd_en;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_valid_d;
        end
    end

    // Read hit tells software whether the data came from this bank
    always_comb begin
        rd_hit_d = rd_accept;  // see R08
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_hit_q <= 1'b0;
        end else begin
            rd_hit_q <= rd_hit_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rd_valid = rd_valid_q;
    assign reg_rd_hit = rd_hit_q;

    assign coef_num4 = coef[refcb_pkg::SLOT_NUM4];
    assign coef_num5 = coef[refcb_pkg::SLOT_NUM5];
    assign coef_den1 = coef[refcb_pkg::SLOT_DEN1];
    assign coef_den2 = coef[refcb_pkg::SLOT_DEN2];
    assign coef_den4 = coef[refcb_pkg::SLOT_DEN4];
endmodule : refcb_coef_bank

// [tb/refcb_coef_bank_assertions.sv]
// Port-level checker for the coefficient bank
`timescale 1ns/1ps
module refcb_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control port
    input wire logic [7:0] page_sel,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic reg_rd_hit,
    // Coefficients
    input wire logic signed [15:0] coef_num4,
    input wire logic signed [15:0] coef_num5,
    input wire logic signed [15:0] coef_den1,
    input wire logic signed [15:0] coef_den2,
    input wire logic signed [15:0] coef_den4
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_wr_low; reg_wr_en && page_sel == 8'h01 && reg_addr == 7'h2c
        |=> coef_den4[7:0] == $past(reg_wdata); endproperty
    a_wr_low: assert property (p_wr_low) else $error("den4 low byte");
    property p_n4; $fell(rst) |-> coef_num4 == 16'h9666; endproperty
    a_n4: assert property (p_n4) else $error("num4 reset");
    property p_n5; $fell(rst) |-> coef_num5 == 16'h675d; endproperty
    a_n5: assert property (p_n5) else $error("num5 reset");
    property p_d1; $fell(rst) |-> coef_den1 == 16'h7d83; endproperty
    a_d1: assert property (p_d1) else $error("den1 reset");
    property p_d2; $fell(rst) |-> coef_den2 == 16'h84ee; endproperty
    a_d2: assert property (p_d2) else $error("den2 reset");
    property p_d4; $fell(rst) |-> coef_den4 == 16'h7d83; endproperty
    a_d4: assert property (p_d4) else $error("den4 reset");
    property p_rd; reg_rd_en && !reg_wr_en && page_sel == 8'h01 && reg_addr == 7'h23
        |=> reg_rd_hit && 16'(reg_rdata) == ($past(coef_num4) >> 8); endproperty
    a_rd: assert property (p_rd) else $error("readback");
    property p_miss; reg_rd_en && (page_sel != 8'h01 || reg_addr < 7'h23 || reg_addr > 7'h2c)
        |=> reg_rd_valid && !reg_rd_hit && reg_rdata == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("miss read");
endmodule : refcb_chk
bind refcb_coef_bank refcb_chk u_chk (.*);

// [tb/refcb_coef_bank_tb.sv]
// Self-checking bench for the coefficient bank
`timescale 1ns/1ps
`define CHK(a, e) begin \
    total_checks++; \
    if ((a) !== (e)) begin \
        err_total++; \
        $display("ERROR %0t %h %h", $time, (a), (e)); \
    end \
end
module refcb_coef_bank_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] page_sel = 8'h01;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rd_valid;
    logic reg_rd_hit;
    logic signed [15:0] coef_num4, coef_num5, coef_den1, coef_den2, coef_den4;
    logic [79:0] coef_all;
    logic [7:0] exp_b [10];
    int err_total = 0;
    int total_checks = 0;
    refcb_coef_bank DUT (.*);
    assign coef_all = {coef_num4, coef_num5, coef_den1, coef_den2, coef_den4};
    always #4 clk = ~clk;
    // One strobe cycle, then one idle cycle so no strobe is driven twice in one step;
    // the read answer is taken at the falling edge after the strobe, while it stands
    task automatic acc(
        input logic [7:0] p,
        input logic [6:0] a,
        input logic w,
        input logic [7:0] d,
        output logic [9:0] rsp
    );
        page_sel = p;
        reg_addr = a;
        reg_wr_en = w;
        reg_rd_en = !w;
        reg_wdata = d;
        @(negedge clk);
        rsp = {reg_rd_valid, reg_rd_hit, reg_rdata};
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        @(negedge clk);
    endtask : acc
    task automatic t_reset();
        logic [9:0] rsp;
        exp_b = '{8'h96, 8'h66, 8'h67, 8'h5d, 8'h7d, 8'h83, 8'h84, 8'hee, 8'h7d, 8'h83};
        `CHK(coef_all, 80'h9666675d7d8384ee7d83)
        for (int i = 0; i < 10; i++) begin
            acc(8'h01, 7'(35 + i), 1'b0, 8'h00, rsp);
            `CHK(rsp, {2'b11, exp_b[i]})
        end
    endtask : t_reset
    // Writes to every byte, sign bit set on numerator 4
    task automatic t_rw();
        logic [79:0] exp_all;
        logic [9:0] rsp;
        for (int i = 0; i < 10; i++) begin
            exp_b[i] = 8'h80 - 8'(11 * i);
            acc(8'h01, 7'(35 + i), 1'b1, exp_b[i], rsp);
            `CHK(rsp, 10'h000)
        end
        exp_all = {>>{exp_b}};
        `CHK(coef_all, exp_all)
        `CHK(coef_num4 < 16'sd0, 1'b1)
        for (int i = 0; i < 10; i++) begin
            acc(8'h01, 7'(35 + i), 1'b0, 8'h00, rsp);
            `CHK(rsp, {2'b11, exp_b[i]})
        end
    endtask : t_rw
    // Wrong page and both neighbours of the window
    task automatic t_miss();
        logic [7:0] p;
        logic [6:0] a;
        logic [9:0] rsp;
        logic [79:0] exp_all;
        exp_all = {>>{exp_b}};
        for (int j = 0; j < 3; j++) begin
            p = (j == 0) ? 8'h00 : 8'h01;
            a = (j == 1) ? 7'h22 : ((j == 2) ? 7'h2d : 7'h23);
            acc(p, a, 1'b1, 8'h5a, rsp);
            acc(p, a, 1'b0, 8'h00, rsp);
            `CHK(rsp, 10'h200)
            `CHK(coef_all, exp_all)
        end
    endtask : t_miss
    task automatic finish_test();
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // The run needs about 100 cycles; 2500 cycles leave ample margin
    initial begin
        #20000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_rw();
        t_miss();
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        finish_test();
    end
endmodule : refcb_coef_bank_tb
